// ===== logic/sync_route_pkg.sv
`default_nettype none
package sync_route_pkg;

   // Register page and offsets
   localparam logic [2:0] PAGE_ZERO    = 3'h0;
   localparam logic [7:0] SELECT_ADDR  = 8'h18;
   localparam logic [7:0] DISABLE_ADDR = 8'h19;
   localparam logic [7:0] SELECT_RESET  = 8'h00;
   localparam logic [7:0] DISABLE_RESET = 8'h00;
   localparam logic [7:0] DISABLE_MASK  = 8'h3f;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // sync_route_select fields
   localparam int DECODER_FROM_LINK_ENABLE_BIT = 0;
   localparam int SLICER_SELECT_BIT            = 1;
   localparam int LINE_REGEN_PIN_INPUT_BIT     = 2;
   localparam int VSYNC_OUTPUT_ENABLE_BIT      = 3;
   localparam int SLICER_TO_VSYNC_PIN_BIT      = 4;
   localparam int FRONT_PORT_DECODER_BIT       = 5;
   localparam int FRONT_PORT_LINK_BIT          = 6;
   localparam int FRONT_PORT_REGEN_SELECT_BIT  = 7;

   // sync_route_disable fields
   localparam int DETECTOR_DECODER_BIT          = 0;
   localparam int DETECTOR_LINK_BIT             = 1;
   localparam int DETECTOR_REGEN_SELECT_BIT     = 2;
   localparam int SLICER_VBLANK_GATE_BIT        = 3;
   localparam int LOCKED_LOOP_LINE_POLARITY_BIT = 4;
   localparam int LOCKED_LOOP_FRAME_POLARITY_BIT = 5;

   // Timing
   localparam int CLK_MHZ         = 40;
   localparam int BROAD_PULSE_NS  = 10000;
   localparam int LINE_GAP_NS     = 20000;
   localparam int REGEN_WIDTH_NS  = 2000;
   localparam logic [11:0] BROAD_PULSE_CYC =
      12'((BROAD_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [11:0] LINE_GAP_CYC =
      12'((LINE_GAP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [11:0] REGEN_WIDTH_CYC =
      12'((REGEN_WIDTH_NS * CLK_MHZ + 999) / 1000);

   typedef struct packed {
      logic hsync_pin;
      logic vsync_pin;
      logic slicer;
      logic link_line_pulse;
      logic link_frame_pulse;
      logic link_data_enable;
   } sync_src_t;

   typedef struct packed {
      logic line;
      logic frame;
   } sync_pair_t;

   typedef enum logic {
      DEC_LINES = 1'b0,
      DEC_FRAME = 1'b1
   } dec_state_t;

endpackage
`default_nettype wire

// ===== logic/sync_pulse_routing.sv
// What this block does
// - Decoder takes link data enable, else slicer if selected, else hsync pin.
// - With vblank gate set, slicer is switched off during decoded vsync.
// - Composite decoder splits its input into line and frame pulses.
// - Regenerator gives regular line pulses; input decoder line or hsync pin.
// - Locked loop syncs come from pins, or decoder when front port decoder select set.
// - Detector syncs: decoder or regenerated by selects, else link, else pins.
// - Front port syncs use the same priority with its own three selects.
// - Link line and frame syncs are selectable sources for detector and front port.
// - Vsync pin is input when output enable is 0, output when 1.
// - Vsync pin drives slicer, else link vsync, else decoder vsync.
// - All selections live in two page zero registers at 18h and 19h.
`timescale 1ns/10ps
`default_nettype none
module sync_pulse_routing (
   input  wire logic                   i_clk_sys,  // System clock, 40 MHz
   input  wire logic                   i_nrst,     // Async reset, low
   input  wire sync_route_pkg::sync_src_t i_src,   // Sync sources
   input  wire logic                   i_slicer_enable, // Green slicer on
   input  wire logic [2:0]             i_reg_page,  // Register page
   input  wire logic [7:0]             i_reg_addr,  // Register offset
   input  wire logic [7:0]             i_reg_wdata, // Write data
   input  wire logic                   i_reg_wr,    // Write strobe
   input  wire logic                   i_reg_rd,    // Read strobe
   output logic [7:0]                  o_reg_rdata, // Read data
   output logic                        o_slicer_enable, // Slicer gate
   output logic                        o_decoder_line_pulse,  // Decoder hs
   output logic                        o_decoder_frame_pulse, // Decoder vs
   output logic                        o_regenerated_line_pulse, // Regen hs
   output sync_route_pkg::sync_pair_t  o_locked_loop_input, // To line PLL
   output sync_route_pkg::sync_pair_t  o_detector_input,    // To detector
   output sync_route_pkg::sync_pair_t  o_front_port_input,  // To front port
   output logic                        o_vsync_out, // Vsync pin drive
   output logic                        o_vsync_oe,  // Vsync pin enable
   output logic                        o_locked_loop_line_polarity,  // Hs pol
   output logic                        o_locked_loop_frame_polarity  // Vs pol
);

   typedef struct packed {
      logic [7:0]                 select_reg;
      logic [7:0]                 disable_reg;
      logic [7:0]                 rdata;
      logic                       slicer_on;
      sync_route_pkg::dec_state_t dec_state;
      logic [11:0]                pulse_cnt;
      logic [11:0]                gap_cnt;
      logic                       dec_line;
      logic                       rg_prev;
      logic                       rg_seen;
      logic                       rg_lock;
      logic [11:0]                rg_cnt;
      logic [11:0]                rg_period;
      logic [11:0]                rg_width;
      sync_route_pkg::sync_pair_t pll;
      sync_route_pkg::sync_pair_t det;
      sync_route_pkg::sync_pair_t front;
      logic                       vs_oe;
      logic                       vs_out;
   } state_t;

   state_t state_reg;
   state_t state_next;

   function automatic logic [11:0] sat_inc(input logic [11:0] v);
      sat_inc = (v == 12'hfff) ? v : v + 12'h001;
   endfunction

   // Sampled line spacing may wander by one clock
   function automatic logic spans_agree(input logic [11:0] a,
                                        input logic [11:0] b);
      spans_agree = (a == b) || (a == b + 12'h001) || (b == a + 12'h001);
   endfunction

   // Shared consumer priority: composite path first, then link over pins
   function automatic sync_route_pkg::sync_pair_t pick(
      input logic                       cs_sel,
      input logic                       link_sel,
      input logic                       regen_sel,
      input sync_route_pkg::sync_src_t  src,
      input sync_route_pkg::sync_pair_t dec,
      input logic                       regen);
      sync_route_pkg::sync_pair_t p;
      p.line  = src.hsync_pin;
      p.frame = src.vsync_pin;
      if (cs_sel) begin
         if (regen_sel) begin
            p.line  = regen;
            p.frame = dec.frame;
         end else begin
            p = dec;
         end
      end else if (link_sel) begin
         p.line  = src.link_line_pulse;
         p.frame = src.link_frame_pulse;
      end
      pick = p;
   endfunction

   logic                       link_sel;
   logic                       composite;
   logic                       rg_in;
   logic                       rg_rise;
   logic                       rg_accept;
   logic [11:0]                rg_span;
   logic                       rg_match;
   logic                       page_hit;
   sync_route_pkg::sync_pair_t dec_pair;

   always_comb begin
      state_next = state_reg;
      link_sel = state_reg.select_reg[
         sync_route_pkg::DECODER_FROM_LINK_ENABLE_BIT];
      page_hit = (i_reg_page == sync_route_pkg::PAGE_ZERO);

      // Register writes and reads
      if (i_reg_wr && page_hit) begin
         if (i_reg_addr == sync_route_pkg::SELECT_ADDR) begin
            state_next.select_reg = i_reg_wdata;
         end else if (i_reg_addr == sync_route_pkg::DISABLE_ADDR) begin
            state_next.disable_reg =
               i_reg_wdata & sync_route_pkg::DISABLE_MASK;
         end
      end
      if (i_reg_rd) begin
         if (page_hit && i_reg_addr == sync_route_pkg::SELECT_ADDR) begin
            state_next.rdata = state_reg.select_reg;
         end else if (page_hit &&
                      i_reg_addr == sync_route_pkg::DISABLE_ADDR) begin
            state_next.rdata = state_reg.disable_reg;
         end else begin
            state_next.rdata = sync_route_pkg::UNMAPPED_READ;
         end
      end

      // Decoder input
      if (link_sel) begin
         composite = i_src.link_data_enable;
      end else if (state_reg.select_reg[
                      sync_route_pkg::SLICER_SELECT_BIT]) begin
         composite = i_src.slicer;
      end else begin
         composite = i_src.hsync_pin;
      end

      // Slicer held off through the decoded frame pulse
      state_next.slicer_on = i_slicer_enable &
         ~(state_reg.disable_reg[sync_route_pkg::SLICER_VBLANK_GATE_BIT] &
           (state_reg.dec_state == sync_route_pkg::DEC_FRAME));

      // Broad pulses mark the frame; a long quiet gap ends it
      if (composite) begin
         state_next.pulse_cnt = sat_inc(state_reg.pulse_cnt);
         state_next.gap_cnt   = 12'h000;
      end else begin
         state_next.gap_cnt   = sat_inc(state_reg.gap_cnt);
         state_next.pulse_cnt = 12'h000;
      end
      case (state_reg.dec_state)
         sync_route_pkg::DEC_LINES: begin
            if (composite && state_reg.pulse_cnt >=
                sync_route_pkg::BROAD_PULSE_CYC - 12'h001) begin
               state_next.dec_state = sync_route_pkg::DEC_FRAME;
            end
         end
         sync_route_pkg::DEC_FRAME: begin
            if (!composite && state_reg.gap_cnt >=
                sync_route_pkg::LINE_GAP_CYC - 12'h001) begin
               state_next.dec_state = sync_route_pkg::DEC_LINES;
            end
         end
         default: begin
            state_next.dec_state = sync_route_pkg::DEC_LINES;
         end
      endcase
      // Line pulses are suppressed in the frame; the regenerator fills in
      state_next.dec_line = composite &
         (state_reg.dec_state == sync_route_pkg::DEC_LINES);
      dec_pair.line  = state_reg.dec_line;
      dec_pair.frame = (state_reg.dec_state == sync_route_pkg::DEC_FRAME);

      // Flywheel regenerator; early edges such as equalizing pulses
      // inside the first three quarters of a line are ignored
      rg_in = state_reg.select_reg[
         sync_route_pkg::LINE_REGEN_PIN_INPUT_BIT] ?
         i_src.hsync_pin : state_reg.dec_line;
      rg_rise = rg_in & ~state_reg.rg_prev;
      rg_accept = rg_rise && (state_reg.rg_cnt >=
         state_reg.rg_period - {2'b00, state_reg.rg_period[11:2]});
      rg_span = sat_inc(state_reg.rg_cnt);
      // Lock on two agreeing spacings wide enough that pulses never merge;
      // a frame gap or a burst of closely spaced edges is not learned
      rg_match = state_reg.rg_seen &&
         spans_agree(rg_span, state_reg.rg_period) &&
         ({1'b0, rg_span[11:1]} > sync_route_pkg::REGEN_WIDTH_CYC);
      state_next.rg_prev = rg_in;
      state_next.rg_cnt  = sat_inc(state_reg.rg_cnt);
      if (state_reg.rg_width != 12'h000) begin
         state_next.rg_width = state_reg.rg_width - 12'h001;
      end
      if (!state_reg.rg_lock) begin
         if (rg_rise) begin
            state_next.rg_cnt    = 12'h000;
            state_next.rg_seen   = 1'b1;
            state_next.rg_period = state_reg.rg_seen ? rg_span : 12'h000;
            if (rg_match) begin
               state_next.rg_lock  = 1'b1;
               state_next.rg_width = sync_route_pkg::REGEN_WIDTH_CYC;
            end
         end
      end else if (rg_accept) begin
         state_next.rg_period = sat_inc(state_reg.rg_cnt);
         state_next.rg_cnt    = 12'h000;
         state_next.rg_width  = sync_route_pkg::REGEN_WIDTH_CYC;
      end else if (state_reg.rg_cnt >=
                   state_reg.rg_period - 12'h001) begin
         state_next.rg_cnt   = 12'h000;
         state_next.rg_width = sync_route_pkg::REGEN_WIDTH_CYC;
      end

      // Consumer routing, registered
      if (state_reg.select_reg[sync_route_pkg::FRONT_PORT_DECODER_BIT])
      begin
         state_next.pll = dec_pair;
      end else begin
         state_next.pll.line  = i_src.hsync_pin;
         state_next.pll.frame = i_src.vsync_pin;
      end
      state_next.det = pick(
         state_reg.disable_reg[sync_route_pkg::DETECTOR_DECODER_BIT],
         state_reg.disable_reg[sync_route_pkg::DETECTOR_LINK_BIT],
         state_reg.disable_reg[sync_route_pkg::DETECTOR_REGEN_SELECT_BIT],
         i_src, dec_pair, state_reg.rg_width != 12'h000);
      state_next.front = pick(
         state_reg.select_reg[sync_route_pkg::FRONT_PORT_DECODER_BIT],
         state_reg.select_reg[sync_route_pkg::FRONT_PORT_LINK_BIT],
         state_reg.select_reg[sync_route_pkg::FRONT_PORT_REGEN_SELECT_BIT],
         i_src, dec_pair, state_reg.rg_width != 12'h000);

      // Vsync pin direction and source
      state_next.vs_oe = state_reg.select_reg[
         sync_route_pkg::VSYNC_OUTPUT_ENABLE_BIT];
      if (state_reg.select_reg[sync_route_pkg::SLICER_TO_VSYNC_PIN_BIT])
      begin
         state_next.vs_out = i_src.slicer;
      end else if (link_sel) begin
         state_next.vs_out = i_src.link_frame_pulse;
      end else begin
         state_next.vs_out = dec_pair.frame;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg             <= '0;
         state_reg.select_reg  <= sync_route_pkg::SELECT_RESET;
         state_reg.disable_reg <= sync_route_pkg::DISABLE_RESET;
         state_reg.dec_state   <= sync_route_pkg::DEC_LINES;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_reg_rdata              = state_reg.rdata;
   assign o_slicer_enable          = state_reg.slicer_on;
   assign o_decoder_line_pulse     = state_reg.dec_line;
   assign o_decoder_frame_pulse    =
      (state_reg.dec_state == sync_route_pkg::DEC_FRAME);
   assign o_regenerated_line_pulse = (state_reg.rg_width != 12'h000);
   assign o_locked_loop_input      = state_reg.pll;
   assign o_detector_input         = state_reg.det;
   assign o_front_port_input       = state_reg.front;
   assign o_vsync_out              = state_reg.vs_out;
   assign o_vsync_oe               = state_reg.vs_oe;
   // Polarity only passes through; software matches it to the source
   assign o_locked_loop_line_polarity  = state_reg.disable_reg[
      sync_route_pkg::LOCKED_LOOP_LINE_POLARITY_BIT];
   assign o_locked_loop_frame_polarity = state_reg.disable_reg[
      sync_route_pkg::LOCKED_LOOP_FRAME_POLARITY_BIT];

endmodule
`default_nettype wire

// ===== verification/sync_route_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sync_route_properties (
   input wire logic                       i_clk_sys, i_nrst,
   input wire logic                       i_slicer_enable, i_reg_wr, i_reg_rd,
   input wire logic [2:0]                 i_reg_page,
   input wire logic [7:0]                 i_reg_addr, i_reg_wdata, o_reg_rdata,
   input wire sync_route_pkg::sync_src_t  i_src,
   input wire logic                       o_slicer_enable, o_vsync_out,
   input wire logic                       o_vsync_oe, o_decoder_frame_pulse,
   input wire logic                       o_regenerated_line_pulse,
   input wire sync_route_pkg::sync_pair_t o_locked_loop_input,
   input wire sync_route_pkg::sync_pair_t o_detector_input, o_front_port_input
);
   logic [7:0] sel_reg, dis_reg;
   // Shadow copies of the two routing registers, from the write strobes
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_reg <= 8'h00;
         dis_reg <= 8'h00;
      end else if (i_reg_wr && i_reg_page == 3'h0) begin
         if (i_reg_addr == 8'h18) sel_reg <= i_reg_wdata;
         if (i_reg_addr == 8'h19) dis_reg <= i_reg_wdata & 8'h3f;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // Outputs are still zero at the first edge after reset, hence the guard
   property p_pll_pins; $past(i_nrst) && !$past(sel_reg[5]) |->
      o_locked_loop_input == {$past(i_src.hsync_pin), $past(i_src.vsync_pin)};
   endproperty
   a_pll_pins: assert property (p_pll_pins) else $error("pll pins");
   property p_det_link; $past(i_nrst) && $past(dis_reg[1:0]) == 2'h2 |->
      o_detector_input == {$past(i_src.link_line_pulse),
                           $past(i_src.link_frame_pulse)};
   endproperty
   a_det_link: assert property (p_det_link) else $error("det link");
   property p_front_regen; $past(sel_reg[5]) && $past(sel_reg[7]) |->
      o_front_port_input.frame == $past(o_decoder_frame_pulse);
   endproperty
   a_front_regen: assert property (p_front_regen)
      else $error("fp vs");
   property p_vs_dir; $past(i_nrst) |-> o_vsync_oe == $past(sel_reg[3]);
   endproperty
   a_vs_dir: assert property (p_vs_dir) else $error("vsync dir");
   property p_vs_link; $past(sel_reg[4:3]) == 2'h1 && $past(sel_reg[0]) |->
      o_vsync_out == $past(i_src.link_frame_pulse);
   endproperty
   a_vs_link: assert property (p_vs_link) else $error("vsync link");
   property p_slicer_on; $past(i_nrst) && !$past(dis_reg[3]) |->
      o_slicer_enable == $past(i_slicer_enable);
   endproperty
   a_slicer_on: assert property (p_slicer_on) else $error("slicer on");
   property p_rd; i_reg_rd && i_reg_page == 3'h0 && i_reg_addr == 8'h19 |=>
      o_reg_rdata == $past(dis_reg);
   endproperty
   a_rd: assert property (p_rd) else $error("read data");
   property p_regen_width; $rose(o_regenerated_line_pulse) |->
      ##79 o_regenerated_line_pulse ##1 !o_regenerated_line_pulse;
   endproperty
   a_regen_width: assert property (p_regen_width) else $error("regen");
endmodule
bind sync_pulse_routing sync_route_properties u_props (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_slicer_enable(i_slicer_enable),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_page(i_reg_page),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_src(i_src),
   .o_reg_rdata(o_reg_rdata), .o_slicer_enable(o_slicer_enable),
   .o_vsync_out(o_vsync_out), .o_vsync_oe(o_vsync_oe),
   .o_decoder_frame_pulse(o_decoder_frame_pulse),
   .o_regenerated_line_pulse(o_regenerated_line_pulse),
   .o_locked_loop_input(o_locked_loop_input),
   .o_detector_input(o_detector_input),
   .o_front_port_input(o_front_port_input));
`default_nettype wire

// ===== verification/sync_source.sv
`timescale 1ns/10ps
`default_nettype none
module sync_source (
   input  wire logic                      i_clk_sys,  // Bench clock
   input  wire logic                      i_csync_on, // Composite on hsync
   input  wire sync_route_pkg::sync_src_t i_level,    // Static levels
   output sync_route_pkg::sync_src_t      o_src       // To the block
);
   logic [11:0] cnt_reg = 12'h000;
   logic        cs;
   // Broad pulse, long idle, then lines; no equalizers at all
   assign cs = cnt_reg < 12'h1f4 ||
               (cnt_reg >= 12'h578 && cnt_reg % 12'h0c8 < 12'h028);
   always @(posedge i_clk_sys) begin
      cnt_reg <= i_csync_on ? cnt_reg + 12'h001 : 12'h000;
   end
   always_comb begin
      o_src = i_level;
      if (i_csync_on) begin
         o_src.hsync_pin = cs;
         o_src.slicer    = cs;
      end
   end
endmodule
`default_nettype wire

// ===== verification/tb_sync_pulse_routing.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sync_pulse_routing;
   logic                       i_clk_sys = 1'b0;
   logic                       i_nrst = 1'b0;
   logic                       cs_on = 1'b0, slc_in = 1'b0;
   logic                       wr = 1'b0, rd = 1'b0;
   logic [2:0]                 page = 3'h0;
   logic [7:0]                 addr = 8'h00, wdata = 8'h00, rdata;
   sync_route_pkg::sync_src_t  lvl = '0, src;
   sync_route_pkg::sync_pair_t pll, det, fp;
   logic                       slc_en, dec_ln, dec_fr, regen;
   logic                       vs_out, vs_oe, pol_ln, pol_fr;
   int                         compares = 0, n_mismatch = 0;

   always #12.5 i_clk_sys = ~i_clk_sys;

   sync_source partner (.i_clk_sys(i_clk_sys), .i_csync_on(cs_on),
      .i_level(lvl), .o_src(src));
   sync_pulse_routing DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
      .i_src(src), .i_slicer_enable(slc_in), .i_reg_page(page),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .o_slicer_enable(slc_en),
      .o_decoder_line_pulse(dec_ln), .o_decoder_frame_pulse(dec_fr),
      .o_regenerated_line_pulse(regen), .o_locked_loop_input(pll),
      .o_detector_input(det), .o_front_port_input(fp), .o_vsync_out(vs_out),
      .o_vsync_oe(vs_oe), .o_locked_loop_line_polarity(pol_ln),
      .o_locked_loop_frame_polarity(pol_fr));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wr_reg(input logic [2:0] pg, input logic [7:0] a, d);
      @(posedge i_clk_sys);
      page <= pg;
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      page <= 3'h0;
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk_sys);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic drive(input logic [5:0] v);
      @(posedge i_clk_sys);
      lvl <= v;
   endtask

   task automatic t_regs;
      rd_chk(8'h18, 8'h00);
      wr_reg(3'h0, 8'h19, 8'hff);
      rd_chk(8'h19, 8'h3f);
      wr_reg(3'h1, 8'h18, 8'hff);
      rd_chk(8'h18, 8'h00);
      rd_chk(8'h20, 8'h00);
      wr_reg(3'h0, 8'h19, 8'h30); // Both syncs are active high
      cyc(1);
      chk({6'h00, pol_fr, pol_ln}, 8'h03);
      $display("registers done");
   endtask
   task automatic t_pins;
      wr_reg(3'h0, 8'h19, 8'h00);
      drive(6'h30);
      cyc(2);
      chk({2'h0, pll, det, fp}, 8'h3f);
      wr_reg(3'h0, 8'h19, 8'h02);
      wr_reg(3'h0, 8'h18, 8'h40);
      drive(6'h04);
      cyc(2);
      chk({2'h0, pll, det, fp}, 8'h0a);
      $display("pin routing done");
   endtask
   task automatic t_vpin;
      logic [7:0] s [4] = '{8'h10, 8'h18, 8'h09, 8'h08};
      logic [7:0] e [4] = '{8'h00, 8'h02, 8'h03, 8'h02};
      drive(6'h02);
      foreach (s[i]) begin
         wr_reg(3'h0, 8'h18, s[i]);
         cyc(2);
         chk({6'h00, vs_oe, vs_out & vs_oe}, e[i]);
      end
      $display("vsync pin done");
   endtask
   task automatic t_dec;
      logic [7:0] s [3] = '{8'h01, 8'h02, 8'h00};
      logic [5:0] on [3] = '{6'h01, 6'h08, 6'h20};
      @(posedge i_clk_sys);
      slc_in <= 1'b1; // Slicer powered before it is a source
      foreach (s[i]) begin
         wr_reg(3'h0, 8'h18, s[i]);
         drive(~on[i] & 6'h29);
         cyc(4);
         chk({7'h00, dec_ln}, 8'h00);
         drive(on[i]);
         cyc(4);
         chk({7'h00, dec_ln}, 8'h01);
      end
      drive(6'h00);
      $display("decoder input done");
   endtask
   task automatic t_comp;
      logic       p;
      logic [7:0] n;
      n = 8'h00;
      wr_reg(3'h0, 8'h19, 8'h0d);
      wr_reg(3'h0, 8'h18, 8'ha4);
      @(posedge i_clk_sys);
      cs_on <= 1'b1;
      cyc(480);
      chk({3'h0, dec_fr, det.frame, slc_en, pll}, 8'h19);
      cyc(1570);
      chk({3'h0, dec_fr, det.frame, slc_en, pll}, 8'h04);
      // Lines every 200 cycles, so 1000 cycles hold five line pulses
      repeat (1000) begin
         p = regen;
         cyc(1);
         if (!p && regen) n++;
      end
      chk(n, 8'h05);
      $display("composite done");
   endtask

   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      t_regs();
      t_pins();
      t_vpin();
      t_dec();
      t_comp();
      close_out();
   end
   initial begin
      #(25 * 8000);
      n_mismatch++;
      $display("watchdog expired");
      close_out();
   end
endmodule
`default_nettype wire
